/* pkg/drs_pkg.sv */
// Constants and carrier types for the digit, borrow, trap and shift execution unit.
// Assumes a decoder upstream supplies operands, size and the current flags.
//
// Functional notes
// RULE1: Rotate digit right: dst low nibble to link, dst high to low, link to high.
// RULE2: Rotate digit sets zero from link result; other flags kept.
// RULE3: Link and destination must be different byte registers; same gives undefined result.
// RULE4: Subtract with borrow adds inverted source plus not-carry; source untouched.
// RULE5: Carry cleared on carry out of msb, set otherwise as borrow.
// RULE6: Subtract sets zero on zero result and sign on negative result.
// RULE7: Overflow when operand signs differ and result sign equals source sign.
// RULE8: Byte subtract sets decimal-adjust, half-carry is borrow from bit 3.
// RULE9: System call pushes status at sp-6 then instruction word at sp-8; code pushes the word only if no request follows in the next cycle.
// RULE10: System call word is all-ones first byte then 8-bit service number; code expects first byte 7f instead.
// RULE11: System call raises trap; flags come from newly loaded status.
// RULE12: Dynamic shift count is signed 16-bit; positive left, negative right.
// RULE13: Right shift replicates sign; carry is last bit out of lsb.
// RULE14: Left shift fills zero at lsb; carry is last bit out of msb.
// RULE15: Zero count keeps destination but sets flags from it.
// RULE16: Count must lie within plus or minus the operand width.
// RULE17: Shift carry cleared on zero count or last bit zero.
// RULE18: Shift sets zero, sign, and overflow if sign changed during shifting.
// RULE19: Shift decoded from size field 110011/110010 and nibble 1011/1111.
// RULE20: Byte, word and longword widths select msb, sign and carry position.
package drs_pkg;
   // ****************************************
   // Operation and size encodings
   // ****************************************
   typedef enum logic [2:0] {DRS_OP_NONE, DRS_OP_RRD, DRS_OP_SBC, DRS_OP_SC, DRS_OP_SDA} drs_op_e;
   typedef enum logic [1:0] {DRS_SZ_BYTE, DRS_SZ_WORD, DRS_SZ_LONG} drs_size_e;

   // ****************************************
   // Field positions and constants
   // ****************************************
   localparam int DRS_NIB_LO_LSB = 0;
   localparam int DRS_NIB_HI_LSB = 4;
   localparam int DRS_HALF_BIT = 3;
   localparam logic [31:0] DRS_SC_PS_DEC = 32'h0000_0006;
   localparam logic [31:0] DRS_SC_IW_DEC = 32'h0000_0002;
   localparam logic [7:0] DRS_SC_OPCODE = 8'h7f;
   localparam logic [5:0] DRS_SDA_SIZE_WL = 6'h33;
   localparam logic [5:0] DRS_SDA_SIZE_B = 6'h32;
   localparam logic [3:0] DRS_SDA_FN_BW = 4'hb;
   localparam logic [3:0] DRS_SDA_FN_L = 4'hf;
   localparam logic [15:0] DRS_FLAGS_RST = 16'h0000;
   localparam logic [31:0] DRS_SP_RST = 32'h0000_0000;

   // Flags carried between decoder and unit
   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic v;
      logic d;
      logic h;
   } drs_flags_s;

   // One issued operation
   typedef struct packed {
      drs_op_e op;
      drs_size_e size;
      logic [31:0] dst;
      logic [31:0] src;
      logic [15:0] iword;
   } drs_req_s;

   // Stack write request
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [47:0] data;
      logic wide;
   } drs_stk_s;
endpackage

/* hdl/drs_shifter.sv */
// Dynamic arithmetic shifter, combinational.
// Assumes the count lies within plus or minus the operand width.
`timescale 1ns/1ps
module drs_shifter #(
   parameter int WIDTH = 32
) (
   input wire logic [WIDTH-1:0] value,
   input wire logic [15:0] count,
   input wire drs_pkg::drs_size_e size,
   output logic [WIDTH-1:0] result,
   output logic carry,
   output logic ovf
);
   import drs_pkg::*;

   // Refuse widths that the width helpers cannot serve
   if (WIDTH != 32) begin : g_width_check
      $error("drs_shifter serves 32-bit operands only");
   end

   // ****************************************
   // Bit-serial model unrolled over the width
   // ****************************************
   function automatic int msb_of(input drs_size_e sz);
      msb_of = (sz == DRS_SZ_BYTE) ? 7 : (sz == DRS_SZ_WORD) ? 15 : 31; // RULE20
   endfunction

   // Shift one step at a time so carry and sign history are exact
   always_comb begin
      logic [WIDTH-1:0] v;
      logic signed [15:0] n;
      int msb;
      int k;
      v = value;
      n = $signed(count); // RULE12
      msb = msb_of(size);
      carry = 1'b0; // RULE17
      ovf = 1'b0;
      k = (n < 0) ? -int'(n) : int'(n);
      for (int i = 0; i < 33; i++) begin
         if (i < k) begin
            if (n > 0) begin
               carry = v[msb]; // RULE14
               v = v << 1;
               if (v[msb] != value[msb]) ovf = 1'b1; // RULE18
            end else begin
               carry = v[0]; // RULE13
               v = v >> 1;
               v[msb] = v[msb-1];
            end
         end
      end
      for (int j = 0; j < WIDTH; j++) begin
         if (j > msb) v[j] = 1'b0;
      end
      result = v; // RULE15
   end
endmodule

/* hdl/drs_unit.sv */
// Execution unit for rotate digit right, subtract with borrow, system call and dynamic shift.
// Assumes one request per cycle from the decoder and a memory stage that takes stack writes.
`timescale 1ns/1ps
module drs_unit (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire drs_pkg::drs_req_s req,
   input wire drs_pkg::drs_flags_s flags_in,
   input wire logic [31:0] sp_in,
   input wire drs_pkg::drs_flags_s sc_ps_flags,
   output logic res_valid,
   output logic [31:0] dst_out,
   output logic [7:0] link_out,
   output drs_pkg::drs_flags_s flags_out,
   output logic [31:0] sp_out,
   output drs_pkg::drs_stk_s stk_out,
   output logic trap_sc,
   output logic [7:0] service_num,
   output logic bad_decode
);
   import drs_pkg::*;

   // ****************************************
   // State and reset synchroniser
   // ****************************************
   typedef struct packed {
      logic res_valid;
      logic [31:0] dst;
      logic [7:0] link;
      drs_flags_s flags;
      logic [31:0] sp;
      drs_stk_s stk;
      logic trap;
      logic [7:0] svc;
      logic bad;
      logic [15:0] iw;
   } drs_state_s;

   drs_state_s st_reg;
   drs_state_s st_next;
   logic [1:0] rst_sync_reg;
   logic rst_n;

   // Two-stage release of the asynchronous reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ****************************************
   // Width helpers
   // ****************************************
   function automatic int msb_of(input drs_size_e sz);
      msb_of = (sz == DRS_SZ_BYTE) ? 7 : (sz == DRS_SZ_WORD) ? 15 : 31; // RULE20
   endfunction

   function automatic logic [31:0] mask_of(input drs_size_e sz);
      mask_of = (sz == DRS_SZ_BYTE) ? 32'h0000_00ff : (sz == DRS_SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
   endfunction

   // First-word check for the dynamic shift: size field and function nibble
   function automatic logic sda_word_ok(input drs_size_e sz, input logic [15:0] iw);
      logic [5:0] fld;
      logic [3:0] fn;
      fld = (sz == DRS_SZ_BYTE) ? DRS_SDA_SIZE_B : DRS_SDA_SIZE_WL;
      fn = (sz == DRS_SZ_LONG) ? DRS_SDA_FN_L : DRS_SDA_FN_BW;
      sda_word_ok = (iw[13:8] == fld) && (iw[3:0] == fn); // RULE19
   endfunction

   // ****************************************
   // Shifter instance
   // ****************************************
   logic [31:0] sh_res;
   logic sh_c;
   logic sh_v;

   drs_shifter #(.WIDTH(32)) u_shift (
      .value(req.dst & mask_of(req.size)),
      .count(req.src[15:0]),
      .size(req.size),
      .result(sh_res),
      .carry(sh_c),
      .ovf(sh_v)
   );

   // ****************************************
   // Subtract datapath
   // ****************************************
   logic [32:0] sub_sum;
   logic [4:0] sub_half;
   logic [31:0] sub_res;
   logic [31:0] sub_nsrc;
   int sub_msb;

   // Destination plus inverted source plus not-carry
   always_comb begin
      sub_nsrc = ~req.src & mask_of(req.size);
      sub_sum = {1'b0, req.dst & mask_of(req.size)} + {1'b0, sub_nsrc} + {32'h0, ~flags_in.c}; // RULE4
      sub_half = {1'b0, req.dst[3:0]} + {1'b0, sub_nsrc[3:0]} + {4'h0, ~flags_in.c};
      sub_res = sub_sum[31:0] & mask_of(req.size);
      sub_msb = msb_of(req.size);
   end

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      logic [7:0] lnk;
      logic [7:0] dd;
      logic cout;
      st_next = st_reg;
      st_next.res_valid = 1'b0;
      st_next.trap = 1'b0;
      st_next.stk = '0;
      st_next.bad = 1'b0;
      lnk = req.src[7:0];
      dd = req.dst[7:0];
      cout = 1'b0;
      if (req_valid) begin
         st_next.res_valid = 1'b1;
         st_next.flags = flags_in;
         st_next.dst = req.dst;
         st_next.link = req.src[7:0];
         unique case (req.op)
            DRS_OP_RRD: begin
               // Three-digit rotate right by one digit
               st_next.link = {lnk[7:4], dd[3:0]}; // RULE1
               st_next.dst = {req.dst[31:8], lnk[3:0], dd[7:4]}; // RULE1 RULE3
               st_next.flags.z = ({lnk[7:4], dd[3:0]} == 8'h00); // RULE2
            end
            DRS_OP_SBC: begin
               cout = sub_sum[sub_msb + 1];
               if (sub_msb < 31) cout = sub_sum[sub_msb + 1];
               else cout = sub_sum[32];
               st_next.dst = (req.dst & ~mask_of(req.size)) | sub_res;
               st_next.flags.c = ~cout; // RULE5
               st_next.flags.z = (sub_res == 32'h0); // RULE6
               st_next.flags.s = sub_res[sub_msb]; // RULE6
               st_next.flags.v = (req.dst[sub_msb] != req.src[sub_msb]) &&
                                 (sub_res[sub_msb] == req.src[sub_msb]); // RULE7
               if (req.size == DRS_SZ_BYTE) begin
                  st_next.flags.d = 1'b1; // RULE8
                  st_next.flags.h = ~sub_half[4]; // RULE8
               end
            end
            DRS_OP_SC: begin
               // Status push at sp-6 and new status now; instruction word at sp-8 next cycle if no request
               if (req.iword[15:8] == DRS_SC_OPCODE) begin // RULE10
                  st_next.sp = sp_in - DRS_SC_PS_DEC - DRS_SC_IW_DEC; // RULE9
                  st_next.stk.valid = 1'b1;
                  st_next.stk.wide = 1'b1;
                  st_next.stk.addr = sp_in - DRS_SC_PS_DEC; // RULE9
                  st_next.stk.data = {req.dst, 10'h0, flags_in.c, flags_in.z, flags_in.s, flags_in.v,
                                      flags_in.d, flags_in.h};
                  st_next.svc = req.iword[7:0]; // RULE10
                  st_next.iw = req.iword;
                  st_next.trap = 1'b1; // RULE11
                  st_next.flags = sc_ps_flags; // RULE11
               end else begin
                  st_next.bad = 1'b1;
               end
            end
            DRS_OP_SDA: begin
               // Only a well-formed shift word is executed; anything else is refused
               if (sda_word_ok(req.size, req.iword)) begin // RULE19
                  st_next.dst = (req.dst & ~mask_of(req.size)) | sh_res; // RULE15
                  st_next.flags.c = sh_c; // RULE17
                  st_next.flags.z = (sh_res == 32'h0); // RULE18
                  st_next.flags.s = sh_res[msb_of(req.size)]; // RULE18
                  st_next.flags.v = sh_v; // RULE18
               end else begin
                  st_next.bad = 1'b1; // RULE19
               end
            end
            default: begin
               st_next.res_valid = 1'b0;
            end
         endcase
      end else if (st_reg.trap) begin
         // Second push: instruction word below the status
         st_next.stk.valid = 1'b1;
         st_next.stk.wide = 1'b0;
         st_next.stk.addr = st_reg.sp; // RULE9
         st_next.stk.data = {32'h0, st_reg.iw}; // RULE9
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.sp <= DRS_SP_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   AST_RRD_Z: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
      (req_valid && req.op == DRS_OP_RRD) |=> (flags_out.z == (link_out == 8'h00)) &&
      (flags_out.c == $past(flags_in.c)))
      else $error("rotate digit zero flag wrong");
   AST_RRD_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
      (req_valid && req.op == DRS_OP_RRD) |=> dst_out[7:4] == $past(req.src[3:0]))
      else $error("rotate digit high nibble wrong");
   AST_SBC_C: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
      (req_valid && req.op == DRS_OP_SBC && req.size == DRS_SZ_BYTE) |=>
      flags_out.c == ({1'b0, $past(req.dst[7:0])} < ({1'b0, $past(req.src[7:0])} + {8'h0, $past(flags_in.c)})))
      else $error("borrow flag wrong");
   AST_SBC_D: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
      (req_valid && req.op == DRS_OP_SBC && req.size == DRS_SZ_BYTE) |=> flags_out.d)
      else $error("decimal-adjust not set");
   AST_SBC_Z: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
      (req_valid && req.op == DRS_OP_SBC && req.size == DRS_SZ_LONG) |=> flags_out.z == (dst_out == 32'h0))
      else $error("subtract zero flag wrong");
   AST_SC_SP: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
      (req_valid && req.op == DRS_OP_SC && req.iword[15:8] == DRS_SC_OPCODE) |=>
      trap_sc && sp_out == $past(sp_in) - 32'h8 ##1 stk_out.valid && stk_out.addr == sp_out)
      else $error("system call stack sequence wrong");
   AST_SC_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE11
      (req_valid && req.op == DRS_OP_SC && req.iword[15:8] == DRS_SC_OPCODE) |=> flags_out == $past(sc_ps_flags))
      else $error("system call flags not loaded");
   AST_SDA_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE15
      (req_valid && req.op == DRS_OP_SDA && sda_word_ok(req.size, req.iword) && req.src[15:0] == 16'h0000) |=>
      dst_out == $past(req.dst) && !flags_out.c)
      else $error("zero count shift altered destination");
   AST_SDA_DECODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE19
      (req_valid && req.op == DRS_OP_SDA && !sda_word_ok(req.size, req.iword)) |=> bad_decode && !trap_sc)
      else $error("bad shift word not refused");
   AST_SDA_RIGHT_SIGN: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
      (req_valid && req.op == DRS_OP_SDA && sda_word_ok(req.size, req.iword) && req.size == DRS_SZ_LONG &&
      req.src[15]) |=> dst_out[31] == $past(req.dst[31]))
      else $error("right shift lost the sign");
   AST_SDA_LEFT_FILL: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE14
      (req_valid && req.op == DRS_OP_SDA && sda_word_ok(req.size, req.iword) && !req.src[15] &&
      req.src[15:0] != 16'h0000) |=> !dst_out[0])
      else $error("left shift did not fill zero");
   AST_SC_SVC: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
      (req_valid && req.op == DRS_OP_SC && req.iword[15:8] == DRS_SC_OPCODE) |=>
      service_num == $past(req.iword[7:0]) && stk_out.wide ##1
      !stk_out.wide && stk_out.data[15:0] == $past(req.iword, 2))
      else $error("system call service or word push wrong");

   // ****************************************
   // Outputs
   // ****************************************
   assign res_valid = st_reg.res_valid;
   assign dst_out = st_reg.dst;
   assign link_out = st_reg.link;
   assign flags_out = st_reg.flags;
   assign sp_out = st_reg.sp;
   assign stk_out = st_reg.stk;
   assign trap_sc = st_reg.trap;
   assign service_num = st_reg.svc;
   assign bad_decode = st_reg.bad;
endmodule

/* verif/drs_unit_tb.sv */
// Self-checking bench for the digit, borrow, trap and shift execution unit.
// Assumes drs_pkg is compiled first; the bench drives every unit input itself.
`timescale 1ns/1ps
module drs_unit_tb;
   import drs_pkg::*;
   // ****************************************
   // Expected-result note and signals
   // ****************************************
   typedef struct packed {
      drs_op_e op;
      logic bad;
      logic [31:0] dst;
      logic [7:0] link;
      drs_flags_s fl;
      logic [31:0] sp;
      logic [47:0] ps;
      logic [15:0] iw;
   } drs_exp_s;
   logic clk_sys, rst_b, req_valid, res_valid, trap_sc, bad_decode;
   logic push2 = 1'b0;
   drs_req_s req;
   drs_flags_s flags_in, sc_ps_flags, flags_out;
   logic [31:0] sp_in, dst_out, sp_out;
   logic [7:0] link_out, service_num;
   drs_stk_s stk_out;
   drs_exp_s notes[$];
   drs_exp_s e2;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;

   drs_unit u_drs_unit (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req(req),
      .flags_in(flags_in), .sp_in(sp_in), .sc_ps_flags(sc_ps_flags), .res_valid(res_valid),
      .dst_out(dst_out), .link_out(link_out), .flags_out(flags_out), .sp_out(sp_out),
      .stk_out(stk_out), .trap_sc(trap_sc), .service_num(service_num), .bad_decode(bad_decode));

   // Clock at 40 ns period
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ****************************************
   // Reference model worked out from the operation definitions
   // ****************************************
   // Well-formed dynamic shift word for a size, built from the encodings
   function automatic logic [15:0] sda_iw(drs_size_e sz);
      return {2'b10, (sz == DRS_SZ_BYTE) ? DRS_SDA_SIZE_B : DRS_SDA_SIZE_WL, 4'h0,
              (sz == DRS_SZ_LONG) ? DRS_SDA_FN_L : DRS_SDA_FN_BW};
   endfunction

   function automatic drs_exp_s calc(drs_req_s r, drs_flags_s f, logic [31:0] sp, drs_flags_s scf);
      drs_exp_s e;
      int w;
      int cnt;
      logic [31:0] m, d, s, res;
      logic [32:0] sum;
      logic [4:0] lo;
      w = (r.size == DRS_SZ_BYTE) ? 8 : (r.size == DRS_SZ_WORD) ? 16 : 32;
      m = (w == 32) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
      d = r.dst & m;
      s = r.src & m;
      res = d;
      e = '0;
      e.op = r.op;
      e.fl = f;
      e.iw = r.iword;
      case (r.op)
         DRS_OP_RRD: begin
            e.link = {r.src[7:4], r.dst[3:0]};
            res = {24'h0, r.src[3:0], r.dst[7:4]};
            e.fl.z = (e.link == 8'h00);
         end
         DRS_OP_SBC: begin
            sum = {1'b0, d} + {1'b0, ~s & m} + {32'h0, ~f.c};
            lo = {1'b0, d[3:0]} + {1'b0, ~s[3:0]} + {4'h0, ~f.c};
            res = sum[31:0] & m;
            e.fl.c = ~sum[w];
            e.fl.v = (d[w-1] != s[w-1]) && (res[w-1] == s[w-1]);
            if (w == 8) begin
               e.fl.d = 1'b1;
               e.fl.h = ~lo[4];
            end
         end
         DRS_OP_SDA: begin
            e.bad = (r.iword != sda_iw(r.size));
            cnt = $signed(r.src[15:0]);
            e.fl.c = 1'b0;
            e.fl.v = 1'b0;
            for (int i = 0; i < cnt; i++) begin
               e.fl.c = res[w-1];
               res = (res << 1) & m;
               if (res[w-1] != d[w-1]) e.fl.v = 1'b1;
            end
            for (int i = 0; i < -cnt; i++) begin
               e.fl.c = res[0];
               res = (res >> 1) | (res & (32'h1 << (w - 1)));
            end
         end
         default: begin
            e.bad = (r.iword[15:8] != DRS_SC_OPCODE);
            e.sp = sp - 32'h8;
            e.ps = {r.dst, 10'h0, f};
            e.link = r.iword[7:0];
            e.fl = scf;
         end
      endcase
      if (r.op == DRS_OP_SBC || r.op == DRS_OP_SDA) begin
         e.fl.z = (res == 32'h0);
         e.fl.s = res[w-1];
      end
      e.dst = (r.dst & ~m) | res;
      return e;
   endfunction

   // ****************************************
   // Checking tasks
   // ****************************************
   task automatic chk(string n, logic [47:0] ex, logic [47:0] got);
      cmp_count++;
      if (got !== ex) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, ex, got);
      end
   endtask

   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Monitor takes the oldest note whenever a result appears
   always @(negedge clk_sys) begin
      drs_exp_s e;
      if (push2 === 1'b1) begin
         chk("stk2", {1'b1, e2.sp, 1'b0}, {stk_out.valid, stk_out.addr, stk_out.wide});
         chk("stk2_data", {32'h0, e2.iw}, stk_out.data);
      end
      push2 = 1'b0;
      if (res_valid === 1'b1 || bad_decode === 1'b1) begin
         if (notes.size() == 0) begin
            chk("unexpected_result", 48'h0, 48'h1);
         end else begin
            e = notes.pop_front();
            case (e.op)
               DRS_OP_RRD: begin
                  chk("rrd_dst", e.dst, dst_out);
                  chk("rrd_link", e.link, link_out);
                  chk("rrd_flags", e.fl, flags_out);
               end
               DRS_OP_SBC: begin
                  chk("sbc_dst", e.dst, dst_out);
                  chk("sbc_c", e.fl.c, flags_out.c);
                  chk("sbc_zs", {e.fl.z, e.fl.s}, {flags_out.z, flags_out.s});
                  chk("sbc_v", e.fl.v, flags_out.v);
                  chk("sbc_dh", {e.fl.d, e.fl.h}, {flags_out.d, flags_out.h});
               end
               DRS_OP_SDA: begin
                  chk("sda_bad", e.bad, bad_decode);
                  if (!e.bad) begin
                     chk("sda_dst", e.dst, dst_out);
                     chk("sda_c", e.fl.c, flags_out.c);
                     chk("sda_zsv", {e.fl.z, e.fl.s, e.fl.v}, {flags_out.z, flags_out.s, flags_out.v});
                  end
               end
               default: begin
                  chk("sc_trap_bad", {~e.bad, e.bad}, {trap_sc, bad_decode});
                  if (!e.bad) begin
                     chk("sc_flags", e.fl, flags_out);
                     chk("sc_sp", e.sp, sp_out);
                     chk("stk1", {1'b1, e.sp + 32'h2, 1'b1}, {stk_out.valid, stk_out.addr, stk_out.wide});
                     chk("stk1_data", e.ps, stk_out.data);
                     chk("sc_service", e.link, service_num);
                     e2 = e;
                     push2 = 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         final_report();
      end
   end

   // ****************************************
   // Stimulus
   // ****************************************
   task automatic issue(drs_op_e op, drs_size_e sz, logic [31:0] d, logic [31:0] s, logic [15:0] iw);
      req_valid = 1'b1;
      req = '{op, sz, d, s, iw};
      flags_in = drs_flags_s'(6'($urandom));
      sp_in = $urandom;
      sc_ps_flags = drs_flags_s'(6'($urandom));
      if (op != DRS_OP_NONE) notes.push_back(calc(req, flags_in, sp_in, sc_ps_flags));
      @(negedge clk_sys);
   endtask

   task automatic idle(int n);
      req_valid = 1'b0;
      repeat (n) @(negedge clk_sys);
   endtask

   initial begin
      int w;
      logic [31:0] bnd[4] = '{32'h0, 32'h0, 32'h8000_0000, 32'h0000_0001};
      rst_b = 1'b0;
      req_valid = 1'b0;
      req = '0;
      flags_in = '0;
      sp_in = '0;
      sc_ps_flags = '0;
      void'($urandom(59965));
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      idle(4);
      // Link and destination come from distinct operands, one zero-link case first
      issue(DRS_OP_RRD, DRS_SZ_BYTE, 32'h1234_5650, 32'h0000_0008, 16'h0);
      for (int i = 0; i < 6; i++) issue(DRS_OP_RRD, DRS_SZ_BYTE, $urandom, $urandom, 16'h0);
      // Borrow chain at every width: boundaries then random, back to back
      for (int z = 0; z < 3; z++) begin
         issue(DRS_OP_SBC, drs_size_e'(z), bnd[0], bnd[1], 16'h0);
         issue(DRS_OP_SBC, drs_size_e'(z), bnd[2] >> (24 - 8 * z * (z == 1) - 24 * (z == 2) + 24 * 0), bnd[3], 16'h0);
         issue(DRS_OP_SBC, drs_size_e'(z), 32'h0000_0038, 32'h0000_000a, 16'h0);
         for (int i = 0; i < 8; i++) issue(DRS_OP_SBC, drs_size_e'(z), $urandom, $urandom, 16'h0);
      end
      // Shift: worked case, every byte count, then random in-range counts
      issue(DRS_OP_SDA, DRS_SZ_WORD, 32'h0000_c705, 32'h0000_fffe, sda_iw(DRS_SZ_WORD));
      for (int c = -8; c <= 8; c++) issue(DRS_OP_SDA, DRS_SZ_BYTE, $urandom, 32'(c), sda_iw(DRS_SZ_BYTE));
      for (int z = 1; z < 3; z++) begin
         w = 16 * z;
         for (int i = 0; i < 10; i++) issue(DRS_OP_SDA, drs_size_e'(z), $urandom, 32'(int'($urandom_range(2 * w, 0)) - w), sda_iw(drs_size_e'(z)));
         issue(DRS_OP_SDA, drs_size_e'(z), $urandom, 32'h0, sda_iw(drs_size_e'(z)));
      end
      // A byte shift carrying the longword function nibble must be refused
      issue(DRS_OP_SDA, DRS_SZ_BYTE, $urandom, 32'h1, sda_iw(DRS_SZ_LONG));
      // System call: lowest, highest and random service, then a bad first byte
      foreach (bnd[i]) begin
         issue(DRS_OP_SC, DRS_SZ_WORD, $urandom, 32'h0, {(i == 3) ? 8'h7e : DRS_SC_OPCODE, (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom)});
         idle(2);
      end
      issue(DRS_OP_NONE, DRS_SZ_BYTE, $urandom, $urandom, 16'h0);
      idle(5);
      chk("notes_left", 48'h0, 48'(notes.size()));
      final_report();
   end
endmodule
